//--- pfc_filter_ctrl.sv
/*
 * Control and status for a packet-identifier filter and the host write port
 * of a packet-insertion RAM, plus the filtering stage of the stream path.
 * Assumes the host-interface logic runs on mclk and presents single-cycle
 * read and write strobes; the insertion engine, also on mclk, drives the
 * insertion enable level and reads the RAM through its own index; the
 * per-location buffer map comes from its own registers elsewhere.
 */
module pfc_filter_ctrl
    import pfc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Host register access
    input wire pfc_pkg::pfc_host_req_t host_req,
    output pfc_pkg::pfc_host_rsp_t host_rsp,
    // Buffer map per filter location
    input wire logic [pfc_pkg::NUM_LOC-1:0][pfc_pkg::BUF_W-1:0] buf_map,
    // Insertion engine
    input wire logic insert_enable,
    input wire logic [pfc_pkg::INS_PTR_W-1:0] ins_rd_index,
    output logic [pfc_pkg::DATA_W-1:0] ins_rd_data,
    output logic [pfc_pkg::INS_PTR_W-1:0] ins_wr_pointer,
    // Stream in
    input wire logic str_in_valid,
    output logic str_in_ready,
    input wire pfc_pkg::pfc_beat_t str_in,
    // Stream out
    output pfc_pkg::pfc_route_t str_out,
    input wire logic str_out_ready
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_LOC-1:0][DATA_W-1:0] filt;  // Filter comparison values
        logic filter_enable;                   // Filtering active
        logic [PTR_W-1:0] filter_read_pointer;
        logic [PTR_W-1:0] filter_write_pointer;
        logic [BUF_W-1:0] selected_stream_buffer;
        logic [INS_PTR_W-1:0] ins_wptr;        // Insertion write pointer
        logic [INS_PTR_W-1:0] ins_rptr;        // Insertion host read pointer
        logic ins_en_d;                        // Insertion enable, last cycle
        pfc_host_rsp_t rsp;                    // Read answer
        pfc_route_t out;                       // Output stage
        logic in_ready;                        // Registered FIFO ready copy
    } pfc_ctrl_state_t;

    pfc_ctrl_state_t st_r;
    pfc_ctrl_state_t st_nxt;

    // Insertion storage, deliberately outside the reset state
    logic [DATA_W-1:0] ins_ram [INS_DEPTH];
    logic [DATA_W-1:0] ins_rd_q;               // Host read word

    // Stream path wires
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    pfc_beat_t fifo_out;
    logic match_hit;
    logic [BUF_W-1:0] match_buf;

    // Host strobe decode
    logic rd_facc;
    logic wr_facc;
    logic rd_csr;
    logic wr_csr;
    logic rd_iacc;
    logic wr_iacc;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Address match for a strobe
    function automatic logic hit_at(input logic strobe, input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
        hit_at = strobe && (a == off);
    endfunction : hit_at

    // Control and status word; reserved positions are zero
    function automatic logic [DATA_W-1:0] csr_word(input pfc_ctrl_state_t s);
        logic [DATA_W-1:0] w;
        w = CSR_RESET;
        w[CSR_FILTER_READ_POINTER_LSB +: PTR_W] = s.filter_read_pointer;
        w[CSR_FILTER_WRITE_POINTER_LSB +: PTR_W] = s.filter_write_pointer;
        w[CSR_SELBUF_LSB +: BUF_W] = s.selected_stream_buffer;
        w[CSR_ENABLE_BIT] = s.filter_enable;
        csr_word = w;
    endfunction : csr_word

    assign rd_facc = hit_at(host_req.rd, host_req.addr, OFF_FILTER_ACC);
    assign wr_facc = hit_at(host_req.wr, host_req.addr, OFF_FILTER_ACC);
    assign rd_csr = hit_at(host_req.rd, host_req.addr, OFF_FILTER_CSR);
    assign wr_csr = hit_at(host_req.wr, host_req.addr, OFF_FILTER_CSR);
    assign rd_iacc = hit_at(host_req.rd, host_req.addr, OFF_INSERT_ACC);
    assign wr_iacc = hit_at(host_req.wr, host_req.addr, OFF_INSERT_ACC);

    // ------------------------------------------------------------------
    // Stream path
    // ------------------------------------------------------------------
    // Input buffer; only beats the source sees accepted are pushed, never twice
    pfc_fifo #(
        .WIDTH($bits(pfc_beat_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rst(srst),
        .in_valid(str_in_valid && str_in_ready),
        .in_ready(fifo_in_ready),
        .in_data(str_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );

    // Compare head beat against the filter table
    pfc_pid_match u_match (
        .table_val(st_r.filt),
        .buf_map(buf_map),
        .pid(fifo_out.pid),
        .hit(match_hit),
        .hit_buf(match_buf)
    );

    // Head beat leaves when the output stage is free or being emptied
    assign fifo_out_ready = !st_r.out.valid || str_out_ready;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.ins_en_d = insert_enable;
        st_nxt.rsp.valid = 1'b0;
        // Ready copy; a word is accepted only while the FIFO really has room
        st_nxt.in_ready = fifo_in_ready;

        // Output stage drains on acceptance
        if (st_r.out.valid && str_out_ready) begin
            st_nxt.out.valid = 1'b0;
        end

        // Filtering stage
        if (fifo_out_valid && fifo_out_ready) begin
            if (st_r.filter_enable) begin
                if (match_hit) begin
                    st_nxt.out.valid = 1'b1;
                    st_nxt.out.pid = fifo_out.pid;
                    st_nxt.out.data = fifo_out.data;
                    st_nxt.out.buf_sel = match_buf;
                    st_nxt.selected_stream_buffer = match_buf;
                end
            end else begin
                st_nxt.out.valid = 1'b1;
                st_nxt.out.pid = fifo_out.pid;
                st_nxt.out.data = fifo_out.data;
                st_nxt.out.buf_sel = fifo_out.dflt_buf;
            end
        end

        // Host reads: answer one cycle later, unmapped reads return zero
        if (host_req.rd) begin
            st_nxt.rsp.valid = 1'b1;
            st_nxt.rsp.rdata = '0;
            if (rd_facc) begin
                st_nxt.rsp.rdata = st_r.filt[st_r.filter_read_pointer];
            end else if (rd_csr) begin
                st_nxt.rsp.rdata = csr_word(st_r);
            end else if (rd_iacc) begin
                if (!insert_enable) begin
                    st_nxt.rsp.rdata = ins_rd_q;
                end
            end
        end

        // Filter access port read
        if (rd_facc) begin
            if (!st_r.filter_enable) begin
                st_nxt.filter_read_pointer = st_r.filter_read_pointer + 1'b1;
            end
        end

        // Filter access port write
        if (wr_facc) begin
            if (!st_r.filter_enable) begin
                st_nxt.filt[st_r.filter_write_pointer] = host_req.wdata;
                st_nxt.filter_write_pointer = st_r.filter_write_pointer + 1'b1;
            end
        end

        // Control write; only enable and clear are writable
        if (wr_csr) begin
            st_nxt.filter_enable = host_req.wdata[CSR_ENABLE_BIT];
            if (host_req.wdata[CSR_ENABLE_BIT] && !st_r.filter_enable) begin
                st_nxt.filter_read_pointer = PTR_RESET;
            end
            // clear wins over a same-cycle access
            if (host_req.wdata[CSR_CLEAR_BIT]) begin
                for (int i = 0; i < NUM_LOC; i++) begin
                    st_nxt.filt[i] = FILTER_RESET;
                end
                st_nxt.filter_read_pointer = PTR_RESET;
                st_nxt.filter_write_pointer = PTR_RESET;
            end
        end

        // Insertion pointers restart when insertion is switched on
        if (insert_enable && !st_r.ins_en_d) begin
            st_nxt.ins_wptr = INS_PTR_RESET;
            st_nxt.ins_rptr = INS_PTR_RESET;
        end else if (!insert_enable) begin
            if (wr_iacc) begin
                st_nxt.ins_wptr = st_r.ins_wptr + 1'b1;
            end
            if (rd_iacc) begin
                st_nxt.ins_rptr = st_r.ins_rptr + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Control state, cleared by reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        // host word stored while insertion is off
        if (wr_iacc && !insert_enable) begin
            ins_ram[st_r.ins_wptr] <= host_req.wdata;
        end
    end

    // Registered engine read port, no reset like the RAM itself
    always_ff @(posedge mclk) begin
        ins_rd_data <= ins_ram[ins_rd_index];
    end

    // Host read word for the insertion port, taken combinationally
    assign ins_rd_q = ins_ram[st_r.ins_rptr];

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign host_rsp = st_r.rsp;
    assign str_out = st_r.out;
    assign ins_wr_pointer = st_r.ins_wptr;
    // Registered ready, gated by the FIFO's own live not-full check
    assign str_in_ready = st_r.in_ready && fifo_in_ready;

endmodule : pfc_filter_ctrl

//--- pfc_pkg.sv
/*
 * Constants, offsets and carrier types shared by the packet-identifier
 * filter control block, its match logic and its stream FIFO.
 * Assumes one 10 MHz clock (mclk) and a synchronous active-high reset (srst)
 * shared with the host-interface logic that issues register strobes.
 */
// Summary of operation
// - Read pointer names next filter location read
// - Filter off: access-port read advances read pointer
// - Enabling filter zeroes the read pointer
// - Filter on: reads leave read pointer alone
// - Write pointer names next filter location written
// - Filter off: access-port write advances write pointer
// - Selected stream buffer field is read-only
// - Clear bit zeroes filter values and pointers
// - Filter on: only matching identifiers are forwarded
// - Filter off: streams pass with routing unchanged
// - Insertion write stores word at write pointer
// - Insertion off: each write advances write pointer
// - Insertion on: access port has no effect
// - Insertion RAM is not cleared by reset
// - Filter writes land at write pointer when off
// - Match routes data to location's mapped buffer
package pfc_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_FILTER_ACC = 8'h9C;  // Filter access port
    localparam logic [ADDR_W-1:0] OFF_FILTER_CSR = 8'hA0;  // Filter control and status
    localparam logic [ADDR_W-1:0] OFF_INSERT_ACC = 8'hA4;  // Insertion access port

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CSR_FILTER_READ_POINTER_LSB = 12;     // Filter read pointer 15:12
    localparam int CSR_FILTER_WRITE_POINTER_LSB = 8;      // Filter write pointer 11:8
    localparam int CSR_SELBUF_LSB = 4;     // Selected stream buffer 6:4
    localparam int CSR_CLEAR_BIT = 1;      // Filter clear strobe
    localparam int CSR_ENABLE_BIT = 0;     // Filter enable
    localparam logic [31:0] CSR_RESET = 32'h0000_0000;
    localparam logic [31:0] FILTER_RESET = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int DATA_W = 32;            // Register and payload width
    localparam int NUM_LOC = 16;           // Filter locations
    localparam int PTR_W = 4;              // Filter pointer width
    localparam int BUF_W = 3;              // Buffer select width
    localparam int PID_W = 13;             // Packet identifier width
    localparam int INS_DEPTH = 64;         // Insertion RAM words
    localparam int INS_PTR_W = 6;          // Insertion pointer width
    localparam int FIFO_DEPTH = 4;         // Stream FIFO words
    localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
    localparam logic [INS_PTR_W-1:0] INS_PTR_RESET = 6'h00;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    // One host access, strobes are single-cycle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } pfc_host_req_t;

    // Read answer, valid one cycle after the read strobe
    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] rdata;
    } pfc_host_rsp_t;

    // Incoming stream beat with its unfiltered destination
    typedef struct packed {
        logic [PID_W-1:0] pid;
        logic [BUF_W-1:0] dflt_buf;
        logic [DATA_W-1:0] data;
    } pfc_beat_t;

    // Forwarded beat with its chosen buffer
    typedef struct packed {
        logic valid;
        logic [BUF_W-1:0] buf_sel;
        logic [PID_W-1:0] pid;
        logic [DATA_W-1:0] data;
    } pfc_route_t;

endpackage : pfc_pkg

//--- pfc_fifo.sv
/*
 * Small synchronous FIFO for stream beats, flip-flop storage.
 * Assumes the same clock and synchronous reset as its user; both sides use
 * valid/ready, and a word moves when both are high at a clock edge.
 */
module pfc_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam int IW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;  // Storage words
        logic [IW-1:0] wp;                 // Write index
        logic [IW-1:0] rp;                 // Read index
        logic [CW-1:0] cnt;                // Words held
    } pfc_fifo_state_t;

    pfc_fifo_state_t st_r;
    pfc_fifo_state_t st_nxt;
    logic push;
    logic pop;

    // Handshakes on both sides
    assign in_ready = (st_r.cnt != CW'(DEPTH));
    assign out_valid = (st_r.cnt != '0);
    assign out_data = st_r.mem[st_r.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Next state: store, advance indices, track occupancy
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = (st_r.wp == IW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == IW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
        end
        if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end else if (pop && !push) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : pfc_fifo

//--- pfc_pid_match.sv
/*
 * Combinational compare of one packet identifier against all filter
 * locations; returns the hit and the mapped buffer of the lowest hit.
 * Assumes table and map are stable register outputs of the same clock.
 */
module pfc_pid_match
    import pfc_pkg::*;
(
    // Filter table and buffer map
    input wire logic [pfc_pkg::NUM_LOC-1:0][pfc_pkg::DATA_W-1:0] table_val,
    input wire logic [pfc_pkg::NUM_LOC-1:0][pfc_pkg::BUF_W-1:0] buf_map,
    // Identifier under test
    input wire logic [pfc_pkg::PID_W-1:0] pid,
    // Result
    output logic hit,
    output logic [pfc_pkg::BUF_W-1:0] hit_buf
);

    // Identifier compare against the low bits of a stored value
    function automatic logic pid_eq(input logic [DATA_W-1:0] v, input logic [PID_W-1:0] p);
        pid_eq = (v[PID_W-1:0] == p);
    endfunction : pid_eq

    // Priority scan, lowest location wins
    always_comb begin
        hit = 1'b0;
        hit_buf = '0;
        for (int i = NUM_LOC - 1; i >= 0; i--) begin
            if (pid_eq(table_val[i], pid)) begin
                hit = 1'b1;
                hit_buf = buf_map[i];
            end
        end
    end

endmodule : pfc_pid_match

//--- pfc_filter_ctrl_chk.sv
/*
 * Checker for the filter control block: host answers, reserved bits,
 * insertion pointer and stream output hold.
 * Assumes one clock mclk and a synchronous active-high srst.
 */
module pfc_filter_ctrl_chk
    import pfc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Host side
    input wire pfc_pkg::pfc_host_req_t host_req,
    input wire pfc_pkg::pfc_host_rsp_t host_rsp,
    // Insertion engine
    input wire logic insert_enable,
    input wire logic [pfc_pkg::INS_PTR_W-1:0] ins_wr_pointer,
    // Stream out
    input wire pfc_pkg::pfc_route_t str_out,
    input wire logic str_out_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // ------------------------------------------------------------
    // Decoded requests
    // ------------------------------------------------------------
    logic rd_csr;
    logic rd_ins;
    logic wr_ins;
    assign rd_csr = host_req.rd && host_req.addr == OFF_FILTER_CSR;
    assign rd_ins = host_req.rd && host_req.addr == OFF_INSERT_ACC;
    assign wr_ins = host_req.wr && host_req.addr == OFF_INSERT_ACC;
    AST_RD_ANSWER: assert property (host_req.rd |=> host_rsp.valid)
        else $error("read strobe got no answer");
    AST_NO_ANSWER: assert property (!host_req.rd |=> !host_rsp.valid)
        else $error("answer without read strobe");
    AST_CSR_RSVD: assert property (rd_csr |=> host_rsp.rdata[31:16] == 16'h0000
        && host_rsp.rdata[7] == 1'b0 && host_rsp.rdata[3:1] == 3'h0)
        else $error("reserved control bits not zero");
    AST_INS_ADV: assert property (wr_ins && !insert_enable
        |=> ins_wr_pointer == $past(ins_wr_pointer) + 6'h01)
        else $error("insertion pointer did not advance");
    AST_INS_HOLD: assert property (insert_enable [*3] |=> $stable(ins_wr_pointer))
        else $error("insertion pointer moved while enabled");
    AST_INS_ZERO: assert property ($rose(insert_enable) |-> ##[1:2] ins_wr_pointer == 6'h00)
        else $error("insertion pointer not zeroed");
    AST_INS_RD_OFF: assert property (rd_ins && insert_enable |=> host_rsp.rdata == 32'h0)
        else $error("insertion read not refused");
    AST_OUT_HOLD: assert property (str_out.valid && !str_out_ready
        |=> str_out.valid && $stable(str_out))
        else $error("stream output changed while stalled");
    // Main scenarios
    cover property (rd_csr);
    cover property (wr_ins && insert_enable);
    cover property (str_out.valid && str_out_ready);
endmodule : pfc_filter_ctrl_chk

bind pfc_filter_ctrl pfc_filter_ctrl_chk u_chk (.mclk(mclk), .srst(srst),
    .host_req(host_req), .host_rsp(host_rsp), .insert_enable(insert_enable),
    .ins_wr_pointer(ins_wr_pointer), .str_out(str_out), .str_out_ready(str_out_ready));

//--- pfc_host_model.sv
/*
 * Host microcontroller model: single-cycle read and write strobes.
 * Assumes the answer comes one cycle after the read edge.
 */
module pfc_host_model
    import pfc_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Host side
    output pfc_pkg::pfc_host_req_t host_req,
    input wire pfc_pkg::pfc_host_rsp_t host_rsp
);
    timeunit 1ns;
    timeprecision 1ns;
    initial host_req = '0;
    // Write strobe, then released lines show inverted values
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge mclk);
        host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr
    // Read strobe, answer taken mid-cycle after the read edge
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
        @(posedge mclk);
        host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~host_req.wdata};
        @(posedge mclk);
        host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: host_req.wdata};
        @(negedge mclk);
        v = host_rsp.valid;
        d = host_rsp.rdata;
    endtask : rd
endmodule : pfc_host_model

//--- tb.sv
/*
 * Testbench for pfc_filter_ctrl: register sequences, stream and insertion.
 * Assumes the host model of pfc_host_model.sv and a 10 MHz mclk.
 */
module tb;
    import pfc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk;
    logic srst;
    pfc_host_req_t host_req;
    pfc_host_rsp_t host_rsp;
    logic [NUM_LOC-1:0][BUF_W-1:0] buf_map;
    logic insert_enable;
    logic [INS_PTR_W-1:0] ins_rd_index;
    logic [INS_PTR_W-1:0] ins_wr_pointer;
    logic [DATA_W-1:0] ins_rd_data;
    logic str_in_valid;
    logic str_in_ready;
    logic str_out_ready = 1'b0;
    pfc_beat_t str_in;
    pfc_route_t str_out;
    pfc_route_t got[$];
    logic [DATA_W-1:0] rd_d;
    logic rd_v;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    pfc_host_model u_host (.mclk(mclk), .host_req(host_req), .host_rsp(host_rsp));
    pfc_filter_ctrl DUT (.mclk(mclk), .srst(srst), .host_req(host_req), .host_rsp(host_rsp),
        .buf_map(buf_map), .insert_enable(insert_enable), .ins_rd_index(ins_rd_index),
        .ins_rd_data(ins_rd_data), .ins_wr_pointer(ins_wr_pointer),
        .str_in_valid(str_in_valid), .str_in_ready(str_in_ready), .str_in(str_in),
        .str_out(str_out), .str_out_ready(str_out_ready));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Downstream stalls one cycle in three; accepted beats are logged
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        str_out_ready <= (cyc % 3 != 0);
    end
    always @(negedge mclk) begin
        if (str_out.valid === 1'b1 && str_out_ready === 1'b1) got.push_back(str_out);
    end
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string m);
        u_host.rd(a, rd_d, rd_v);
        chk(rd_v === 1'b1 && rd_d === e, m);
    endtask : rdc
    // Offer one beat and hold it until accepted
    task automatic send(input pfc_beat_t b);
        int n;
        @(posedge mclk);
        str_in_valid <= 1'b1;
        str_in <= b;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (str_in_ready !== 1'b1 && n < 50);
        @(posedge mclk);
        str_in_valid <= 1'b0;
        str_in <= ~b;
    endtask : send
    task automatic ins_peek(input logic [INS_PTR_W-1:0] i, input logic [DATA_W-1:0] e,
                            input string m);
        @(posedge mclk);
        ins_rd_index <= i;
        @(posedge mclk);
        @(negedge mclk);
        chk(ins_rd_data === e, m);
    endtask : ins_peek
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    // Watchdog well beyond the expected run of under two hundred cycles
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        $display("mismatch at %0t: watchdog expired", $time);
        test_done;
    end
    initial begin
        srst = 1'b1;
        insert_enable = 1'b0;
        ins_rd_index = '0;
        str_in_valid = 1'b0;
        str_in = '0;
        buf_map = '0;
        buf_map[5] = 3'h6;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        rdc(OFF_FILTER_CSR, CSR_RESET, "control reset value");
        for (int i = 0; i < 17; i++) begin
            u_host.wr(OFF_FILTER_ACC, 32'hA000_0100 + i);
            if (i == 0) rdc(OFF_FILTER_CSR, 32'h0000_0100, "write pointer step");
            if (i == 15) rdc(OFF_FILTER_CSR, 32'h0000_0000, "write pointer wrap");
        end
        for (int i = 0; i < 17; i++) begin
            rdc(OFF_FILTER_ACC, 32'hA000_0100 + ((i == 0 || i == 16) ? 16 : i), "location");
        end
        rdc(OFF_FILTER_CSR, 32'h0000_1100, "read pointer wrap and step");
        u_host.wr(OFF_FILTER_CSR, 32'hFFFF_FFFD);
        rdc(OFF_FILTER_CSR, 32'h0000_0101, "enable, read-only and reserved bits");
        u_host.wr(OFF_FILTER_ACC, 32'h0000_0000);
        rdc(OFF_FILTER_ACC, 32'hA000_0110, "write ignored while enabled");
        rdc(OFF_FILTER_CSR, 32'h0000_0101, "pointers hold while enabled");
        send('{pid: 13'h0105, dflt_buf: 3'h1, data: 32'h1111_0001});
        send('{pid: 13'h1FFF, dflt_buf: 3'h2, data: 32'h1111_0002});
        repeat (10) @(posedge mclk);
        chk(got.size() == 1 && got[0].buf_sel === 3'h6 && got[0].pid === 13'h0105
            && got[0].data === 32'h1111_0001, "match");
        got.delete();
        rdc(OFF_FILTER_CSR, 32'h0000_0161, "selected buffer field");
        u_host.wr(OFF_FILTER_CSR, 32'h0000_0000);
        send('{pid: 13'h0105, dflt_buf: 3'h5, data: 32'h1111_0003});
        repeat (10) @(posedge mclk);
        chk(got.size() == 1 && got[0].buf_sel === 3'h5 && got[0].pid === 13'h0105
            && got[0].data === 32'h1111_0003, "pass");
        u_host.wr(OFF_FILTER_CSR, 32'h0000_0002);
        // Clear leaves the selected buffer status of the last match in place
        rdc(OFF_FILTER_CSR, 32'h0000_0060, "clear zeroes pointers");
        rdc(OFF_FILTER_ACC, 32'h0000_0000, "clear zeroes values");
        for (int i = 0; i < 3; i++) u_host.wr(OFF_INSERT_ACC, 32'hC0DE_0000 + i);
        ins_peek(6'h01, 32'hC0DE_0001, "insertion word stored");
        chk(ins_wr_pointer === 6'h03, "insertion pointer advance");
        @(posedge mclk);
        insert_enable <= 1'b1;
        repeat (3) @(posedge mclk);
        u_host.wr(OFF_INSERT_ACC, 32'h0000_0000);
        ins_peek(6'h00, 32'hC0DE_0000, "insertion word kept while enabled");
        chk(ins_wr_pointer === 6'h00, "insertion pointer held");
        rdc(OFF_INSERT_ACC, 32'h0000_0000, "insertion read refused");
        @(posedge mclk);
        insert_enable <= 1'b0;
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        ins_peek(6'h01, 32'hC0DE_0001, "insertion word survives reset");
        test_done;
    end
endmodule : tb
